//--- rtl/irq_mailbox_regs.vh
// mailbox addresses, clear selectors, field positions and strobe length
// assumes inclusion by the mailbox design files only
`ifndef IRQ_MAILBOX_REGS_VH
`define IRQ_MAILBOX_REGS_VH

// ==========================================================================
// host side addresses
`define HOST_STATUS_ADDR 32'h0080_0000
`define HOST_CLEAR_ADDR 32'h0082_0000
`define HOST_DOORBELL_ADDR 32'h0082_0004
`define HOST_MAIL_READ_ADDR 32'h0082_0824
`define HOST_TO_DSP_ADDR 32'h0082_1048

// ==========================================================================
// fpga side addresses
`define FPGA_STATUS_ADDR 32'h0000_0000
`define FPGA_MAIL_ADDR 32'h0000_0824
`define FPGA_TO_HOST_ADDR 32'h0000_1048

// ==========================================================================
// dsp side addresses
`define DSP_STATUS_ADDR 32'ha000_0000
`define DSP_MAIL_ADDR 32'ha000_0824
`define DSP_TO_FPGA_ADDR 32'ha003_1048

// ==========================================================================
// clear selector data values
`define CLEAR_SEL_LOW 32'h0000_0824
`define CLEAR_SEL_HIGH 32'h0000_1048

// ==========================================================================
// field positions
`define CODE_LSB 2
`define CODE_MSB 15
`define CODE_HI_LSB 18
`define CODE_HI_MSB 31
`define FLAG_LOW_BIT 10
`define FLAG_HIGH_BIT 26
`define GRANT_BIT0 0
`define GRANT_BIT1 1
`define GRANT_BIT8 8

// ==========================================================================
// reset values and timing
`define CODE_RESET 14'h0000
`define STROBE_CYCLES 2'h3

`endif

//--- rtl/irq_strobe_gen.v
// active-low interrupt strobe of fixed length, retriggerable
// assumes trigger is a one-cycle pulse on the same clock

`include "irq_mailbox_regs.vh"

module irq_strobe_gen (
  // clock and reset
  input wire i_ref_clk,
  input wire i_rst,
  // trigger and strobe
  input wire i_trigger,
  output wire o_strobe_n
);

  // ========================================================================
  // length counter
  reg [1:0] cnt_q;
  reg strobe_n_q;

  always @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      cnt_q <= 2'h0;
      strobe_n_q <= 1'b1;
    end else begin
      if (i_trigger) begin
        cnt_q <= `STROBE_CYCLES;
      end else if (cnt_q != 2'h0) begin
        cnt_q <= cnt_q - 2'h1;
      end
      strobe_n_q <= ~(i_trigger | (cnt_q > 2'h1));
    end
  end

  assign o_strobe_n = strobe_n_q;

endmodule // irq_strobe_gen

//--- rtl/irq_mailbox.v
// inter-master request mailbox: host, fpga and dsp access ports
// assumes all three access ports are synchronous to i_ref_clk

`include "irq_mailbox_regs.vh"

module irq_mailbox #(
  parameter ADDR_W = 32,
  parameter DATA_W = 32
) (
  // clock and reset
  input wire i_ref_clk,
  input wire i_rst,
  // host access port
  input wire i_host_sel,
  input wire i_host_wr,
  input wire [ADDR_W-1:0] i_host_addr,
  input wire [DATA_W-1:0] i_host_wdata,
  output wire [DATA_W-1:0] o_host_rdata,
  output wire o_host_rvalid,
  // fpga access port
  input wire i_fpga_sel,
  input wire i_fpga_wr,
  input wire [ADDR_W-1:0] i_fpga_addr,
  input wire [DATA_W-1:0] i_fpga_wdata,
  output wire [DATA_W-1:0] o_fpga_rdata,
  output wire o_fpga_rvalid,
  // dsp access port
  input wire i_dsp_sel,
  input wire i_dsp_wr,
  input wire [ADDR_W-1:0] i_dsp_addr,
  input wire [DATA_W-1:0] i_dsp_wdata,
  output wire [DATA_W-1:0] o_dsp_rdata,
  output wire o_dsp_rvalid,
  // bus grant acknowledges shown in host status (bits 0, 1, 8) and dsp status (bits 0, 1)
  input wire [2:0] i_bus_grant_ack,
  // interrupt lines
  output wire o_host_side_irq_to_fpga_n,
  output wire o_dsp_side_irq_to_fpga_n,
  output wire o_dsp_host_irq_input_n
);

  // ========================================================================
  // helpers
  // codes sit in bits 2-15 and 18-31 of a mail word
  function [DATA_W-1:0] place_codes;
    input [13:0] low_code;
    input [13:0] high_code;
    begin
      place_codes = {DATA_W{1'b0}};
      place_codes[`CODE_MSB:`CODE_LSB] = low_code;
      place_codes[`CODE_HI_MSB:`CODE_HI_LSB] = high_code;
    end
  endfunction

  // pending flags sit in bits 10 and 26 of a status word
  function [DATA_W-1:0] place_flags;
    input low_flag;
    input high_flag;
    begin
      place_flags = {DATA_W{1'b0}};
      place_flags[`FLAG_LOW_BIT] = low_flag;
      place_flags[`FLAG_HIGH_BIT] = high_flag;
    end
  endfunction

  // ========================================================================
  // write decode
  wire host_wr = i_host_sel & i_host_wr;
  wire fpga_wr = i_fpga_sel & i_fpga_wr;
  wire dsp_wr = i_dsp_sel & i_dsp_wr;
  wire host_rd = i_host_sel & ~i_host_wr;
  wire fpga_rd = i_fpga_sel & ~i_fpga_wr;
  wire dsp_rd = i_dsp_sel & ~i_dsp_wr;

  // posts, named source then target
  wire post_h2d = host_wr & (i_host_addr == `HOST_TO_DSP_ADDR);
  wire ring_h2f = host_wr & (i_host_addr == `HOST_DOORBELL_ADDR);
  wire post_f2d = fpga_wr & (i_fpga_addr == `FPGA_MAIL_ADDR);
  wire post_f2h = fpga_wr & (i_fpga_addr == `FPGA_TO_HOST_ADDR);
  wire post_d2h = dsp_wr & (i_dsp_addr == `DSP_MAIL_ADDR);
  wire post_d2f = dsp_wr & (i_dsp_addr == `DSP_TO_FPGA_ADDR);

  // clears act only on an exact selector value, other data is ignored
  wire host_clr = host_wr & (i_host_addr == `HOST_CLEAR_ADDR);
  wire fpga_clr = fpga_wr & (i_fpga_addr == `FPGA_STATUS_ADDR);
  wire dsp_clr = dsp_wr & (i_dsp_addr == `DSP_STATUS_ADDR);

  // host as target clears fpga or dsp mail
  wire clr_f2h = host_clr & (i_host_wdata == `CLEAR_SEL_LOW);
  wire clr_d2h = host_clr & (i_host_wdata == `CLEAR_SEL_HIGH);
  // fpga as target clears dsp mail, and the doorbell flag
  wire clr_d2f = fpga_clr & (i_fpga_wdata == `CLEAR_SEL_LOW);
  wire clr_h2f = fpga_clr & (i_fpga_wdata == `CLEAR_SEL_HIGH);
  // dsp as target clears host or fpga mail
  wire clr_h2d = dsp_clr & (i_dsp_wdata == `CLEAR_SEL_LOW);
  wire clr_f2d = dsp_clr & (i_dsp_wdata == `CLEAR_SEL_HIGH);

  // ========================================================================
  // mailbox storage, one code per pair except host-to-fpga
  // sources write these flops, targets read and clear the same ones
  reg [13:0] code_h2d_q;
  reg [13:0] code_f2d_q;
  reg [13:0] code_f2h_q;
  reg [13:0] code_d2h_q;
  reg [13:0] code_d2f_q;

  always @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      code_h2d_q <= `CODE_RESET;
      code_f2d_q <= `CODE_RESET;
      code_f2h_q <= `CODE_RESET;
      code_d2h_q <= `CODE_RESET;
      code_d2f_q <= `CODE_RESET;
    end else begin
      // post beats a same-cycle clear; repeat post overwrites
      if (post_h2d) begin
        code_h2d_q <= i_host_wdata[`CODE_MSB:`CODE_LSB];
      end else if (clr_h2d) begin
        code_h2d_q <= `CODE_RESET;
      end
      if (post_f2d) begin
        code_f2d_q <= i_fpga_wdata[`CODE_MSB:`CODE_LSB];
      end else if (clr_f2d) begin
        code_f2d_q <= `CODE_RESET;
      end
      if (post_f2h) begin
        code_f2h_q <= i_fpga_wdata[`CODE_MSB:`CODE_LSB];
      end else if (clr_f2h) begin
        code_f2h_q <= `CODE_RESET;
      end
      if (post_d2h) begin
        code_d2h_q <= i_dsp_wdata[`CODE_MSB:`CODE_LSB];
      end else if (clr_d2h) begin
        code_d2h_q <= `CODE_RESET;
      end
      if (post_d2f) begin
        code_d2f_q <= i_dsp_wdata[`CODE_MSB:`CODE_LSB];
      end else if (clr_d2f) begin
        code_d2f_q <= `CODE_RESET;
      end
    end
  end

  // ========================================================================
  // pending flags, set wins over clear
  // doorbell flag has no code behind it; the fpga keeps that itself
  reg flag_h2f_q;
  reg flag_h2d_q;
  reg flag_f2d_q;
  reg flag_f2h_q;
  reg flag_d2h_q;
  reg flag_d2f_q;

  always @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      flag_h2f_q <= 1'b0;
      flag_h2d_q <= 1'b0;
      flag_f2d_q <= 1'b0;
      flag_f2h_q <= 1'b0;
      flag_d2h_q <= 1'b0;
      flag_d2f_q <= 1'b0;
    end else begin
      flag_h2f_q <= ring_h2f | (flag_h2f_q & ~clr_h2f);
      flag_h2d_q <= post_h2d | (flag_h2d_q & ~clr_h2d);
      flag_f2d_q <= post_f2d | (flag_f2d_q & ~clr_f2d);
      flag_f2h_q <= post_f2h | (flag_f2h_q & ~clr_f2h);
      flag_d2h_q <= post_d2h | (flag_d2h_q & ~clr_d2h);
      flag_d2f_q <= post_d2f | (flag_d2f_q & ~clr_d2f);
    end
  end

  // ========================================================================
  // read views
  // status shows a master's outgoing flags, mail word its incoming codes
  reg [DATA_W-1:0] host_rdata_d;
  reg [DATA_W-1:0] fpga_rdata_d;
  reg [DATA_W-1:0] dsp_rdata_d;

  always @* begin
    host_rdata_d = {DATA_W{1'b0}};
    if (i_host_addr == `HOST_STATUS_ADDR) begin
      host_rdata_d = place_flags(flag_h2f_q, flag_h2d_q);
      host_rdata_d[`GRANT_BIT0] = i_bus_grant_ack[0];
      host_rdata_d[`GRANT_BIT1] = i_bus_grant_ack[1];
      host_rdata_d[`GRANT_BIT8] = i_bus_grant_ack[2];
    end else if (i_host_addr == `HOST_MAIL_READ_ADDR) begin
      host_rdata_d = place_codes(code_f2h_q, code_d2h_q);
    end
  end

  always @* begin
    fpga_rdata_d = {DATA_W{1'b0}};
    if (i_fpga_addr == `FPGA_STATUS_ADDR) begin
      fpga_rdata_d = place_flags(flag_f2d_q, flag_f2h_q);
    end else if (i_fpga_addr == `FPGA_MAIL_ADDR) begin
      fpga_rdata_d = place_codes(code_d2f_q, 14'h0000);
    end
  end

  always @* begin
    dsp_rdata_d = {DATA_W{1'b0}};
    if (i_dsp_addr == `DSP_STATUS_ADDR) begin
      dsp_rdata_d = place_flags(flag_d2h_q, flag_d2f_q);
      dsp_rdata_d[`GRANT_BIT0] = i_bus_grant_ack[0];
      dsp_rdata_d[`GRANT_BIT1] = i_bus_grant_ack[1];
    end else if (i_dsp_addr == `DSP_MAIL_ADDR) begin
      dsp_rdata_d = place_codes(code_h2d_q, code_f2d_q);
    end
  end

  // ========================================================================
  // registered read answers, held until the next read
  // any read is answered, an unmapped one with zero
  reg [DATA_W-1:0] host_rdata_q;
  reg [DATA_W-1:0] fpga_rdata_q;
  reg [DATA_W-1:0] dsp_rdata_q;
  reg host_rvalid_q;
  reg fpga_rvalid_q;
  reg dsp_rvalid_q;

  always @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      host_rdata_q <= {DATA_W{1'b0}};
      fpga_rdata_q <= {DATA_W{1'b0}};
      dsp_rdata_q <= {DATA_W{1'b0}};
      host_rvalid_q <= 1'b0;
      fpga_rvalid_q <= 1'b0;
      dsp_rvalid_q <= 1'b0;
    end else begin
      host_rvalid_q <= host_rd;
      fpga_rvalid_q <= fpga_rd;
      dsp_rvalid_q <= dsp_rd;
      // reading leaves storage untouched
      if (host_rd) begin
        host_rdata_q <= host_rdata_d;
      end
      if (fpga_rd) begin
        fpga_rdata_q <= fpga_rdata_d;
      end
      if (dsp_rd) begin
        dsp_rdata_q <= dsp_rdata_d;
      end
    end
  end

  assign o_host_rdata = host_rdata_q;
  assign o_fpga_rdata = fpga_rdata_q;
  assign o_dsp_rdata = dsp_rdata_q;
  assign o_host_rvalid = host_rvalid_q;
  assign o_fpga_rvalid = fpga_rvalid_q;
  assign o_dsp_rvalid = dsp_rvalid_q;

  // ========================================================================
  // interrupt strobes; none toward the host
  // fpga-to-dsp interrupt lines are the fpga's own job, none here
  // a post during a running strobe restarts it, giving one leading edge
  irq_strobe_gen u_host_side_strobe (
    .i_ref_clk(i_ref_clk),
    .i_rst(i_rst),
    .i_trigger(ring_h2f),
    .o_strobe_n(o_host_side_irq_to_fpga_n)
  );

  irq_strobe_gen u_dsp_side_strobe (
    .i_ref_clk(i_ref_clk),
    .i_rst(i_rst),
    .i_trigger(post_d2f),
    .o_strobe_n(o_dsp_side_irq_to_fpga_n)
  );

  irq_strobe_gen u_dsp_host_strobe (
    .i_ref_clk(i_ref_clk),
    .i_rst(i_rst),
    .i_trigger(post_h2d),
    .o_strobe_n(o_dsp_host_irq_input_n)
  );

endmodule // irq_mailbox

//--- verif/irq_mailbox_assertions.sv
// assertions on mailbox strobes, read answers, flags and codes
// assumes binding into irq_mailbox, everything on i_ref_clk
module irq_mailbox_assertions (
  input wire i_ref_clk,
  input wire i_rst,
  input wire i_host_sel,
  input wire i_host_wr,
  input wire [31:0] i_host_addr,
  input wire [31:0] i_host_wdata,
  input wire [31:0] o_host_rdata,
  input wire i_fpga_sel,
  input wire i_fpga_wr,
  input wire [31:0] i_fpga_addr,
  input wire [31:0] o_fpga_rdata,
  input wire o_fpga_rvalid,
  input wire i_dsp_sel,
  input wire i_dsp_wr,
  input wire [31:0] i_dsp_addr,
  input wire [31:0] o_dsp_rdata,
  input wire [2:0] i_bus_grant_ack,
  input wire o_host_side_irq_to_fpga_n,
  input wire o_dsp_side_irq_to_fpga_n,
  input wire o_dsp_host_irq_input_n
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (i_rst);
  wire db_w = i_host_sel && i_host_wr && i_host_addr == 32'h0082_0004;
  wire hd_w = i_host_sel && i_host_wr && i_host_addr == 32'h0082_1048;
  wire df_w = i_dsp_sel && i_dsp_wr && i_dsp_addr == 32'ha003_1048;

  // ==========
  // interrupt strobes
  chk_db_strobe: assert property (
    db_w |=> !o_host_side_irq_to_fpga_n [*3]) else $error("doorbell short");
  chk_db_release: assert property (
    db_w ##1 (!db_w) [*3] |=> o_host_side_irq_to_fpga_n)
    else $error("doorbell strobe long");
  chk_hd_strobe: assert property (
    hd_w |=> !o_dsp_host_irq_input_n [*3]) else $error("dsp irq short");
  chk_hd_cause: assert property (
    $fell(o_dsp_host_irq_input_n) |-> $past(hd_w))
    else $error("dsp irq without post");
  chk_df_strobe: assert property (
    df_w |=> !o_dsp_side_irq_to_fpga_n [*3]) else $error("fpga irq short");
  chk_df_cause: assert property (
    $fell(o_dsp_side_irq_to_fpga_n) |-> $past(df_w))
    else $error("fpga irq without post");

  // ==========
  // read answers
  chk_read_answer: assert property (
    o_fpga_rvalid == $past(i_fpga_sel && !i_fpga_wr))
    else $error("fpga read answer wrong");
  chk_grant_bits: assert property (
    i_host_sel && !i_host_wr && i_host_addr == 32'h0080_0000 |=>
    {o_host_rdata[8], o_host_rdata[1:0]} == $past(i_bus_grant_ack))
    else $error("grant bits wrong");
  chk_post_flag: assert property (
    i_fpga_sel && i_fpga_wr && i_fpga_addr == 32'h824 ##1
    i_fpga_sel && !i_fpga_wr && i_fpga_addr == 32'h0 && !i_dsp_sel
    |=> o_fpga_rdata[10]) else $error("pending flag not set");
  chk_mail_code: assert property (
    hd_w ##1 i_dsp_sel && !i_dsp_wr && i_dsp_addr == 32'ha000_0824
    && !i_host_sel |=> o_dsp_rdata[15:2] == $past(i_host_wdata[15:2], 2))
    else $error("posted code wrong");
endmodule // irq_mailbox_assertions

bind irq_mailbox irq_mailbox_assertions chk_u (
  .i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_host_sel(i_host_sel),
  .i_host_wr(i_host_wr), .i_host_addr(i_host_addr),
  .i_host_wdata(i_host_wdata), .o_host_rdata(o_host_rdata),
  .i_fpga_sel(i_fpga_sel), .i_fpga_wr(i_fpga_wr),
  .i_fpga_addr(i_fpga_addr), .o_fpga_rdata(o_fpga_rdata),
  .o_fpga_rvalid(o_fpga_rvalid), .i_dsp_sel(i_dsp_sel),
  .i_dsp_wr(i_dsp_wr), .i_dsp_addr(i_dsp_addr),
  .o_dsp_rdata(o_dsp_rdata), .i_bus_grant_ack(i_bus_grant_ack),
  .o_host_side_irq_to_fpga_n(o_host_side_irq_to_fpga_n),
  .o_dsp_side_irq_to_fpga_n(o_dsp_side_irq_to_fpga_n),
  .o_dsp_host_irq_input_n(o_dsp_host_irq_input_n));

//--- verif/irq_edge_latch_model.sv
// far-side model: fpga and dsp inputs latching strobe leading edges
// assumes active-low strobes launched on the rising clock edge
module irq_edge_latch_model (
  input wire i_ref_clk,
  input wire i_rst,
  input wire [2:0] i_irq_n,
  input wire i_f2d_post,
  output int o_cnt_a,
  output int o_cnt_b,
  output int o_cnt_c,
  output int o_cnt_d
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] last_q;
  int cnt_q [3];
  logic [2:0] hold_q;
  logic masked_last_q;
  int masked_cnt_q;
  wire fpga_dsp_masked_out = (hold_q <= 3'h2);
  assign o_cnt_a = cnt_q[0];
  assign o_cnt_b = cnt_q[1];
  assign o_cnt_c = cnt_q[2];
  assign o_cnt_d = masked_cnt_q;
  // a strobe held low counts once, as a latched leading edge
  always @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      last_q <= 3'h7;
      cnt_q <= '{0, 0, 0};
    end else begin
      last_q <= i_irq_n;
      for (int k = 0; k < 3; k++)
        if (last_q[k] && !i_irq_n[k])
          cnt_q[k] <= cnt_q[k] + 1;
    end
  end
  // fpga toggles the dsp masked line with its own post: two low, then
  // at least two high; the dsp side counts rising edges
  always @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      hold_q <= 3'h0;
      masked_last_q <= 1'b1;
      masked_cnt_q <= 0;
    end else begin
      if (i_f2d_post && hold_q == 3'h0)
        hold_q <= 3'h4;
      else if (hold_q != 3'h0)
        hold_q <= hold_q - 3'h1;
      masked_last_q <= fpga_dsp_masked_out;
      if (!masked_last_q && fpga_dsp_masked_out)
        masked_cnt_q <= masked_cnt_q + 1;
    end
  end
endmodule // irq_edge_latch_model

//--- verif/test_inter_master_irq_mailbox.sv
// self-checking bench: mailbox against an integer model of the pairs
// assumes partner model counts strobes; ports 0 host, 1 fpga, 2 dsp
module test_inter_master_irq_mailbox;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [31:0] PA [6] = '{32'h820004, 32'h821048, 32'h824,
    32'h1048, 32'ha0000824, 32'ha0031048};
  localparam logic [31:0] CA [3] = '{32'h820000, 32'h0, 32'ha0000000};
  localparam logic [31:0] SA [3] = '{32'h800000, 32'h0, 32'ha0000000};
  localparam logic [31:0] MA [3] = '{32'h820824, 32'h824, 32'ha0000824};
  localparam int CL [3][2] = '{'{3, 4}, '{5, 0}, '{1, 2}};
  localparam int ML [3] = '{3, 5, 1};
  localparam int MH [3] = '{4, 0, 2};
  localparam int TP [3] = '{0, 0, 2};
  logic i_ref_clk = 0;
  logic i_rst = 1;
  logic [2:0] sel = 0, wr = 0, gnt = 0;
  logic [31:0] addr [3] = '{default: 0}, wdata [3] = '{default: 0};
  wire [31:0] rdata [3];
  wire [2:0] rvalid, irq_n;
  logic [13:0] code [6] = '{default: 0};
  bit flg [6];
  logic [31:0] pend_exp, d, cd [3];
  int pend_p = -1, p, seed_v, n_errors = 0, tests_run = 0;
  int cnt [4], snap [4];
  wire f2d_post = sel[1] && wr[1] && addr[1] == 32'h824;

  irq_mailbox dut_u (
    .i_ref_clk(i_ref_clk), .i_rst(i_rst),
    .i_host_sel(sel[0]), .i_host_wr(wr[0]), .i_host_addr(addr[0]),
    .i_host_wdata(wdata[0]), .o_host_rdata(rdata[0]),
    .o_host_rvalid(rvalid[0]),
    .i_fpga_sel(sel[1]), .i_fpga_wr(wr[1]), .i_fpga_addr(addr[1]),
    .i_fpga_wdata(wdata[1]), .o_fpga_rdata(rdata[1]),
    .o_fpga_rvalid(rvalid[1]),
    .i_dsp_sel(sel[2]), .i_dsp_wr(wr[2]), .i_dsp_addr(addr[2]),
    .i_dsp_wdata(wdata[2]), .o_dsp_rdata(rdata[2]),
    .o_dsp_rvalid(rvalid[2]), .i_bus_grant_ack(gnt),
    .o_host_side_irq_to_fpga_n(irq_n[0]),
    .o_dsp_host_irq_input_n(irq_n[1]),
    .o_dsp_side_irq_to_fpga_n(irq_n[2]));
  irq_edge_latch_model far_u (.i_ref_clk(i_ref_clk), .i_rst(i_rst),
    .i_irq_n(irq_n), .i_f2d_post(f2d_post), .o_cnt_a(cnt[0]),
    .o_cnt_b(cnt[1]), .o_cnt_c(cnt[2]), .o_cnt_d(cnt[3]));

  always #4 i_ref_clk = ~i_ref_clk;

  // ==========
  // model of codes and flags
  task automatic model_wr(int q, logic [31:0] a, logic [31:0] v);
    for (int k = 2 * q; k < 2 * q + 2; k++)
      if (a == PA[k]) begin
        flg[k] = 1;
        if (k != 0) code[k] = v[15:2];
      end
    if (a == CA[q])
      for (int j = 0; j < 2; j++)
        if (v == (j ? 32'h1048 : 32'h824)) begin
          flg[CL[q][j]] = 0;
          code[CL[q][j]] = 0;
        end
  endtask
  function automatic logic [31:0] exp_rd(int q, logic [31:0] a);
    logic [31:0] r;
    r = 0;
    if (a == SA[q]) begin
      r[10] = flg[2 * q];
      r[26] = flg[2 * q + 1];
      if (q != 1) r[1:0] = gnt[1:0];
      if (q == 0) r[8] = gnt[2];
    end
    if (a == MA[q]) begin
      r[15:2] = code[ML[q]];
      if (q != 1) r[31:18] = code[MH[q]];
    end
    return r;
  endfunction

  // ==========
  // access tasks
  task automatic check_pend();
    if (pend_p >= 0) begin
      tests_run++;
      if (rvalid[pend_p] !== 1'b1 || rdata[pend_p] !== pend_exp) begin
        n_errors++;
        $display("ERROR %0t port %0d read %h exp %h", $time, pend_p,
          rdata[pend_p], pend_exp);
      end
      pend_p = -1;
    end
  endtask
  task automatic acc(int q, bit w, logic [31:0] a, logic [31:0] v);
    @(negedge i_ref_clk);
    check_pend();
    sel = 3'h1 << q;
    wr[q] = w;
    addr[q] = a;
    wdata[q] = v;
    gnt = 3'($urandom);
    if (w) model_wr(q, a, v);
    else pend_p = q;
    if (!w) pend_exp = exp_rd(q, a);
  endtask
  task automatic idle();
    @(negedge i_ref_clk);
    check_pend();
    sel = 0;
  endtask
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  initial begin
    #(8 * 20000);
    n_errors++;
    $display("ERROR %0t watchdog expired", $time);
    end_of_test();
  end

  initial begin
    seed_v = $urandom(32'h5bcfb539);
    repeat (2) @(posedge i_ref_clk);
    @(negedge i_ref_clk);
    i_rst = 0;
    for (int q = 0; q < 3; q++) begin
      acc(q, 0, SA[q], 0);
      acc(q, 0, MA[q], 0);
    end
    idle();
    $display("test reset done");
    acc(1, 1, 32'h824, 32'h0000_abcc);
    acc(1, 0, 32'h0, 0);
    acc(0, 1, 32'h821048, 32'h5555_1234);
    acc(2, 0, 32'ha0000824, 0);
    acc(2, 0, 32'ha0000824, 0);
    acc(2, 1, 32'ha0000000, 32'h824);
    acc(2, 0, 32'ha0000824, 0);
    idle();
    tests_run++;
    if (cnt[3] != 1) begin
      n_errors++;
      $display("ERROR %0t dsp masked line edges %0d", $time, cnt[3]);
    end
    $display("test directed done");
    for (int i = 0; i < 3; i++) begin
      snap = cnt;
      acc(TP[i], 1, PA[i == 2 ? 5 : i], $urandom);
      acc(TP[i], 1, PA[i == 2 ? 5 : i], $urandom);
      repeat (6) idle();
      for (int k = 0; k < 3; k++) begin
        tests_run++;
        if (cnt[k] != snap[k] + (k == i)) begin
          n_errors++;
          $display("ERROR %0t strobe count on line %0d", $time, k);
        end
      end
    end
    $display("test strobes done");
    repeat (300) begin
      p = $urandom % 3;
      d = $urandom;
      cd = '{32'h824, 32'h1048, d};
      case ($urandom % 6)
        0, 1: acc(p, 1, PA[2 * p + $urandom % 2], d);
        2: acc(p, 1, CA[p], cd[$urandom % 3]);
        3: acc(p, 0, SA[p], 0);
        4: acc(p, 0, MA[p], 0);
        default: acc(p, 1'($urandom % 2), $urandom, d);
      endcase
      if ($urandom % 4 == 0) idle();
    end
    idle();
    $display("test random done");
    end_of_test();
  end
endmodule // test_inter_master_irq_mailbox
